/* File: ffc_pkg.sv */
// Purpose: shared constants and types for the flat field correction stage
// Assumes: one pixel-processing clock at 25 MHz, active-low async reset
// Notes:   coefficient word layout, reset values and width limits live here
//
// Summary of operation
// - output equals raw minus offset, times gain
// - gain is UQ2.8 in bits 9..0
// - offset is unsigned six bits, bits 15..10
// - coefficient word is 16-bit little-endian
// - one coefficient word per corrected component, arrival order
// - coefficient chosen by component position in image; address advances on corrected components only
// - correction precedes exchange, lookup and Bayer stages
// - mono, Bayer, RGB at 8..16-bit components
// - image size stays within per-format limit
// - dedicated 512 MB coefficient partition, apart from FIFO
// - one coefficient fetch per corrected component
// - no capture or fetch during blanking
// - cameras keep combined rate within shared budget
// - enable control corrects, disable passes through
package ffc_pkg;

    // ---------------------------------------------------------------
    // coefficient word layout
    // ---------------------------------------------------------------
    localparam int GAIN_LSB      = 0;
    localparam int GAIN_W        = 10;
    localparam int GAIN_FRAC     = 8;
    localparam int OFFSET_LSB    = 10;
    localparam int OFFSET_W      = 6;
    localparam int COEF_W        = 16;
    localparam int BYTE_W        = 8;

    // ---------------------------------------------------------------
    // memory partition and widths
    // ---------------------------------------------------------------
    localparam longint COEF_PART_BYTES = 64'h0000_0000_2000_0000;
    localparam int     COEF_ADDR_W     = 29;
    localparam int     COMP_W_MAX      = 16;
    localparam int     COMP_W_MIN      = 8;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [COEF_ADDR_W-1:0] ADDR_RESET = 29'h0000_0000;
    localparam logic                   FLAG_RESET = 1'h0;

    typedef enum logic [2:0] {
        FFC_IDLE  = 3'b001,
        FFC_FETCH = 3'b010,
        FFC_SEND  = 3'b100
    } ffc_state_t;

endpackage

/* File: ffc_if.sv */
// Purpose: carrier between the correction stage and its stream/memory partner
// Assumes: both ends run on the same clk_i
// Notes:   valid/ready streams; coefficient read is request/response
`timescale 1ns/1ns
`default_nettype none
interface ffc_if #(
    parameter int COMP_W = 16
) (
    input wire logic clk_i
);
    // raw pixel stream from the camera side
    logic                             raw_valid;
    logic                             raw_ready;
    logic [COMP_W-1:0]                raw_component_value;
    logic                             raw_frame_start;
    // coefficient memory read (byte lanes: low byte first)
    logic                             coef_req;
    logic [ffc_pkg::COEF_ADDR_W-1:0]  coef_addr;
    logic                             coef_ack;
    logic [2*ffc_pkg::BYTE_W-1:0]     coef_bytes;
    // corrected stream towards later stages
    logic                             out_valid;
    logic                             out_ready;
    logic [COMP_W-1:0]                corrected_component_value;

    modport device (
        input  clk_i, raw_valid, raw_component_value, raw_frame_start,
               coef_ack, coef_bytes, out_ready,
        output raw_ready, coef_req, coef_addr, out_valid, corrected_component_value
    );
    modport partner (
        input  clk_i, raw_ready, coef_req, coef_addr, out_valid,
               corrected_component_value,
        output raw_valid, raw_component_value, raw_frame_start,
               coef_ack, coef_bytes, out_ready
    );
endinterface
`default_nettype wire

/* File: ffc_core.sv */
// Purpose: per-component flat field correction, device end
// Assumes: partner keeps image size and data rate in budget
// Notes:   one component in flight; fetch, compute, hand on
//          at most one component per four clocks while correcting
`timescale 1ns/1ns
`default_nettype none
module ffc_core #(
    parameter int COMP_W = 16
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // control
    input  wire logic flat_field_enable_control_i,
    // link
    ffc_if.device     link
);
    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // the arithmetic only serves these component widths
    if ((COMP_W != 8) && (COMP_W != 10) && (COMP_W != 12) &&
        (COMP_W != 14) && (COMP_W != 16)) begin : g_bad_width
        $error("ffc_core: unsupported component width");
    end

    if ((COMP_W < ffc_pkg::COMP_W_MIN) || (COMP_W > ffc_pkg::COMP_W_MAX)) begin : g_bad_range
        $error("ffc_core: component width outside supported range");
    end

    // the word decode assumes two byte lanes, gain below offset, no gaps
    if (ffc_pkg::COEF_W != 2 * ffc_pkg::BYTE_W) begin : g_bad_word
        $error("ffc_core: coefficient word is not two bytes");
    end
    if (ffc_pkg::GAIN_LSB + ffc_pkg::GAIN_W != ffc_pkg::OFFSET_LSB) begin : g_bad_gain
        $error("ffc_core: gain field does not meet offset field");
    end
    if (ffc_pkg::OFFSET_LSB + ffc_pkg::OFFSET_W != ffc_pkg::COEF_W) begin : g_bad_offset
        $error("ffc_core: offset field does not end at top of word");
    end
    if (ffc_pkg::GAIN_FRAC >= ffc_pkg::GAIN_W) begin : g_bad_frac
        $error("ffc_core: gain has no integer bits");
    end

    // the address counter must span the whole coefficient partition
    if ((64'h0000_0000_0000_0001 << ffc_pkg::COEF_ADDR_W) !=
        ffc_pkg::COEF_PART_BYTES) begin : g_bad_part
        $error("ffc_core: address width does not span the partition");
    end

    // a frame restart must land on a word boundary
    if (ffc_pkg::ADDR_RESET[0] != 1'b0) begin : g_bad_align
        $error("ffc_core: restart address is not word aligned");
    end

    // one coefficient word of two bytes per corrected component
    localparam logic [ffc_pkg::COEF_ADDR_W-1:0] ADDR_STEP =
        ffc_pkg::COEF_ADDR_W'(ffc_pkg::COEF_W / ffc_pkg::BYTE_W);

    typedef struct packed {
        ffc_pkg::ffc_state_t              st;
        logic [ffc_pkg::COEF_ADDR_W-1:0]  addr;
        logic [COMP_W-1:0]                raw;
        logic                             req;
        logic                             in_rdy;
        logic                             ovalid;
        logic [COMP_W-1:0]                oval;
    } ffc_core_state_t;

    ffc_core_state_t s_q;
    ffc_core_state_t s_d;

    logic [ffc_pkg::COEF_W-1:0] word;
    logic [COMP_W-1:0]          result;

    // ---------------------------------------------------------------
    // arithmetic
    // ---------------------------------------------------------------
    // byte lane 0 carries the low byte of the little-endian word
    assign word = {link.coef_bytes[2*ffc_pkg::BYTE_W-1:ffc_pkg::BYTE_W],
                   link.coef_bytes[ffc_pkg::BYTE_W-1:0]};

    // combinational, so the answer cycle registers the result directly;
    // the multiplier therefore sits on the path from coef_bytes to s_q
    ffc_core_math #(
        .COMP_W   (COMP_W)
    ) ffc_core_math_i (
        .raw_i    (s_q.raw),
        .word_i   (word),
        .result_o (result)
    );

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            ffc_pkg::FFC_IDLE: begin
                // only active pixels arrive as valid, so blanking costs nothing
                if (link.raw_valid && s_q.in_rdy) begin
                    s_d.in_rdy = 1'b0;
                    s_d.raw    = link.raw_component_value;
                    if (link.raw_frame_start)
                        s_d.addr = ffc_pkg::ADDR_RESET;
                    // enable counts only here, so a change between components
                    // never pairs a raw value with a stale decision
                    if (flat_field_enable_control_i) begin
                        s_d.req = 1'b1;
                        s_d.st  = ffc_pkg::FFC_FETCH;
                    end else begin
                        s_d.ovalid = 1'b1;
                        s_d.oval   = link.raw_component_value;
                        s_d.st     = ffc_pkg::FFC_SEND;
                    end
                end
            end
            ffc_pkg::FFC_FETCH: begin
                if (link.coef_ack) begin
                    s_d.req    = 1'b0;
                    // two bytes per component in the partition
                    s_d.addr   = s_q.addr + ADDR_STEP;
                    s_d.ovalid = 1'b1;
                    s_d.oval   = result;
                    s_d.st = ffc_pkg::FFC_SEND;
                end
            end
            ffc_pkg::FFC_SEND: begin
                // one component in flight: the next take waits for acceptance
                if (link.out_ready) begin
                    s_d.ovalid = 1'b0;
                    s_d.in_rdy = 1'b1;
                    s_d.st     = ffc_pkg::FFC_IDLE;
                end
            end
            default: begin
                s_d.st     = ffc_pkg::FFC_IDLE;
                s_d.req    = 1'b0;
                s_d.ovalid = 1'b0;
                s_d.in_rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q.st     <= ffc_pkg::FFC_IDLE;
            s_q.addr   <= ffc_pkg::ADDR_RESET;
            s_q.raw    <= '0;
            s_q.req    <= ffc_pkg::FLAG_RESET;
            s_q.in_rdy <= 1'b1;
            s_q.ovalid <= ffc_pkg::FLAG_RESET;
            s_q.oval   <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.raw_ready                 = s_q.in_rdy;
    assign link.coef_req                  = s_q.req;
    assign link.coef_addr                 = s_q.addr;
    assign link.out_valid                 = s_q.ovalid;
    assign link.corrected_component_value = s_q.oval;
endmodule

// ---------------------------------------------------------------
// coefficient arithmetic
// ---------------------------------------------------------------
module ffc_core_math #(
    parameter int COMP_W = 16
) (
    // operands
    input  wire logic [COMP_W-1:0]          raw_i,
    input  wire logic [ffc_pkg::COEF_W-1:0] word_i,
    // result
    output logic [COMP_W-1:0]               result_o
);
    localparam int                PROD_W   = COMP_W + ffc_pkg::GAIN_W;
    localparam logic [COMP_W-1:0] COMP_MAX = {COMP_W{1'b1}};

    if ((COMP_W != 8) && (COMP_W != 10) && (COMP_W != 12) &&
        (COMP_W != 14) && (COMP_W != 16)) begin : g_bad_width
        $error("ffc_core_math: unsupported component width");
    end

    logic [ffc_pkg::OFFSET_W-1:0] offs;
    logic [ffc_pkg::GAIN_W-1:0]   gain;
    logic [COMP_W-1:0]            diff;
    logic [PROD_W-1:0]            prod;
    logic [PROD_W-1:0]            scaled;

    // a dark level above the raw value would wrap, so the difference floors at
    // zero; the gain has two integer bits, so the product clips at full scale
    always_comb begin
        gain = word_i[ffc_pkg::GAIN_LSB +: ffc_pkg::GAIN_W];
        offs = word_i[ffc_pkg::OFFSET_LSB +: ffc_pkg::OFFSET_W];
        if (raw_i > COMP_W'(offs))
            diff = raw_i - COMP_W'(offs);
        else
            diff = '0;
        prod   = PROD_W'(diff) * PROD_W'(gain);
        scaled = prod >> ffc_pkg::GAIN_FRAC;
        if (scaled > PROD_W'(COMP_MAX))
            result_o = COMP_MAX;
        else
            result_o = scaled[COMP_W-1:0];
    end
endmodule
`default_nettype wire

/* File: ffc_partner.sv */
// Purpose: partner end: feeds components, serves coefficient bytes, sinks output
// Assumes: coefficient words preloaded by the user side, one per corrected component
// Notes:   memory answer comes one cycle after a request is seen
`timescale 1ns/1ns
`default_nettype none
module ffc_partner #(
    parameter int COMP_W = 16
) (
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            reset_n_i,
    // user pixel source
    input  wire logic                            src_valid_i,
    input  wire logic [COMP_W-1:0]               src_value_i,
    input  wire logic                            src_frame_start_i,
    output logic                                 src_ready_o,
    // user coefficient memory read port
    input  wire logic [2*ffc_pkg::BYTE_W-1:0]    mem_bytes_i,
    output logic [ffc_pkg::COEF_ADDR_W-1:0]      mem_addr_o,
    // user sink
    input  wire logic                            sink_ready_i,
    output logic                                 sink_valid_o,
    output logic [COMP_W-1:0]                    sink_value_o,
    // link
    ffc_if.partner                               link
);
    typedef struct packed {
        logic                            ack;
        logic [ffc_pkg::COEF_ADDR_W-1:0] addr;
        logic                            srdy;
        logic                            svalid;
        logic [COMP_W-1:0]               sval;
    } ffc_partner_state_t;

    ffc_partner_state_t s_q;
    ffc_partner_state_t s_d;

    always_comb begin
        s_d        = s_q;
        s_d.ack    = link.coef_req && !s_q.ack;
        s_d.addr   = link.coef_addr;
        s_d.srdy   = link.raw_ready;
        s_d.svalid = link.out_valid;
        s_d.sval   = link.corrected_component_value;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // ready mirrors the core, which is ready while in reset
            s_q <= '{ack: 1'b0, addr: ffc_pkg::ADDR_RESET, srdy: 1'b1,
                     svalid: 1'b0, sval: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // active components only; blanking never raises valid
    assign link.raw_valid           = src_valid_i;
    assign link.raw_component_value = src_value_i;
    assign link.raw_frame_start     = src_frame_start_i;
    assign link.coef_ack            = s_q.ack;
    assign link.coef_bytes          = mem_bytes_i;
    assign link.out_ready           = sink_ready_i;
    assign src_ready_o              = s_q.srdy;
    assign mem_addr_o               = s_q.addr;
    assign sink_valid_o             = s_q.svalid;
    assign sink_value_o             = s_q.sval;
endmodule
`default_nettype wire

/* File: ffc_link_sva.sv */
// Purpose: protocol checks on the link joining core and partner
// Assumes: one clock, active-low async reset
// Notes:   sees link signals only; values are judged by the bench
`timescale 1ns/1ns
`default_nettype none
module ffc_link_sva #(
    parameter int COMP_W = 16
) (
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   reset_n_i,
    // link
    input wire logic                   raw_valid,
    input wire logic                   raw_ready,
    input wire logic                   raw_frame_start,
    input wire logic                   coef_req,
    input wire logic [28:0]            coef_addr,
    input wire logic                   coef_ack,
    input wire logic                   out_valid,
    input wire logic                   out_ready,
    input wire logic [COMP_W-1:0]      corrected_component_value
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_take; raw_valid && raw_ready; endsequence
    sequence s_frame; raw_valid && raw_ready && raw_frame_start; endsequence
    sequence s_done; out_valid && out_ready; endsequence

    a_req_holds: assert property (coef_req && !coef_ack |=> coef_req)
        else $error("fetch dropped before answer");
    a_ack_gives_out: assert property (coef_ack |=> !coef_req && out_valid)
        else $error("answer gave no output");
    a_out_stands: assert property (out_valid && !out_ready |=>
        out_valid && $stable(corrected_component_value))
        else $error("output changed while stalled");
    a_busy_after_take: assert property (s_take |=> !raw_ready)
        else $error("second component taken in flight");
    a_free_after_out: assert property (s_done |=> raw_ready && !out_valid)
        else $error("not free after output taken");
    a_fetch_needs_take: assert property ($rose(coef_req) |-> $past(raw_valid) && $past(raw_ready))
        else $error("fetch without a component");
    a_frame_addr_zero: assert property (s_frame ##1 coef_req |-> coef_addr == 29'h0000_0000)
        else $error("frame start did not restart address");
    a_idle_no_fetch: assert property (raw_ready |-> !coef_req && !out_valid)
        else $error("activity while idle");
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for core and partner joined by the link
// Assumes: 25 MHz clock, memory modelled as a byte array
// Notes:   expected results computed here, not read from the design
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic [15:0] raw;
        logic [15:0] coef;
        logic        en;
        logic        fs;
        logic [15:0] exp;
    } ffc_row_t;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        en_i = 1'b0;
    logic        src_valid = 1'b0;
    logic [15:0] src_value = 16'h0000;
    logic        src_fs = 1'b0;
    logic        sink_ready = 1'b1;
    logic [7:0]  mem [64];
    logic [28:0] mem_addr;
    logic [15:0] mem_bytes;
    logic [15:0] sink_value;
    logic        src_ready;
    logic        sink_valid;
    int          num_errors = 0;
    int          n_compared = 0;
    int          nxt = 0;
    ffc_row_t    rows [7];

    always #20 clk_i = ~clk_i;
    // little-endian word: low byte at the even address
    assign mem_bytes = {mem[mem_addr[5:0]+6'h01], mem[mem_addr[5:0]]};

    ffc_if #(.COMP_W(16)) ffc_if_i (.clk_i(clk_i));
    ffc_core #(.COMP_W(16)) ffc_core_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .flat_field_enable_control_i(en_i), .link(ffc_if_i));
    ffc_partner #(.COMP_W(16)) ffc_partner_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .src_valid_i(src_valid), .src_value_i(src_value), .src_frame_start_i(src_fs),
        .src_ready_o(src_ready), .mem_bytes_i(mem_bytes), .mem_addr_o(mem_addr),
        .sink_ready_i(sink_ready), .sink_valid_o(sink_valid), .sink_value_o(sink_value),
        .link(ffc_if_i));
    ffc_link_sva #(.COMP_W(16)) ffc_link_sva_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .raw_valid(ffc_if_i.raw_valid), .raw_ready(ffc_if_i.raw_ready),
        .raw_frame_start(ffc_if_i.raw_frame_start), .coef_req(ffc_if_i.coef_req),
        .coef_addr(ffc_if_i.coef_addr), .coef_ack(ffc_if_i.coef_ack),
        .out_valid(ffc_if_i.out_valid), .out_ready(ffc_if_i.out_ready),
        .corrected_component_value(ffc_if_i.corrected_component_value));

    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic run_one(input ffc_row_t r, input int stall);
        int k;
        if (r.fs) nxt = 0;
        if (r.en) begin
            mem[nxt] = r.coef[7:0];
            mem[nxt+1] = r.coef[15:8];
            nxt += 2;
        end
        en_i = r.en;
        src_value = r.raw;
        src_fs = r.fs;
        src_valid = 1'b1;
        sink_ready = (stall == 0);
        k = 0;
        while (ffc_if_i.raw_ready !== 1'b1) begin
            @(posedge clk_i); #1;
            k++;
            if (k > 20) begin num_errors++; report_and_stop(); end
        end
        @(posedge clk_i); #1;
        src_valid = 1'b0;
        src_fs = 1'b0;
        if (stall > 0) begin
            repeat (stall) @(posedge clk_i);
            #1 sink_ready = 1'b1;
        end
        k = 0;
        while (sink_valid !== 1'b1) begin
            @(posedge clk_i); #1;
            k++;
            if (k > 20) begin num_errors++; report_and_stop(); end
        end
        check(sink_value, r.exp);
        @(posedge clk_i); #1;
    endtask

    initial begin
        // unity gain, clamp to zero, saturation, full-scale coefficient,
        // pass-through, half gain, frame restart with quarter gain
        rows = '{'{16'h0100, 16'h1100, 1'b1, 1'b1, 16'h00FC},
                 '{16'h0003, 16'h1100, 1'b1, 1'b0, 16'h0000},
                 '{16'hFFFF, 16'h0200, 1'b1, 1'b0, 16'hFFFF},
                 '{16'h1234, 16'hFFFF, 1'b1, 1'b0, 16'h47C2},
                 '{16'hABCD, 16'h0480, 1'b0, 1'b0, 16'hABCD},
                 '{16'h0400, 16'h0480, 1'b1, 1'b0, 16'h01FF},
                 '{16'h0200, 16'h0C40, 1'b1, 1'b1, 16'h007F}};
        for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5A;
        repeat (16) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        foreach (rows[i]) run_one(rows[i], 0);
        run_one(rows[3], 6);
        reset_n_i = 1'b0;
        @(posedge clk_i); #1;
        check({11'h000, sink_valid, src_ready, ffc_if_i.raw_ready, ffc_if_i.coef_req,
               ffc_if_i.out_valid}, 16'h000C);
        reset_n_i = 1'b1;
        nxt = 0;
        run_one('{16'h0300, 16'h1100, 1'b1, 1'b0, 16'h02FC}, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
